// file: i2c_eeprom.sv
`timescale 1ns/1ps
module i2c_eeprom #(
  parameter int TW_CYCLES = eeprom_pkg::TW_CYC,
  parameter int TW_SPAN_CYCLES = eeprom_pkg::TW_SPAN_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic mode_in,
  input wire logic mode_oe_n,
  output logic busy
);
  // Timer must run at least one cycle; span time may not be shorter
  if (TW_CYCLES < 1 || TW_SPAN_CYCLES < TW_CYCLES) begin : g_bad_tw
    $error("i2c_eeprom: program time parameters out of range");
  end

  eeprom_pkg::bus_ev_t ev;

  sync_edge u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // =====================================================================
  // Mode pin
  // =====================================================================
  logic [1:0] mode_s_q, mode_s_d;
  logic mode_raw;
  assign mode_raw = mode_oe_n ? 1'b1 : mode_in;
  always_comb mode_s_d = {mode_s_q[0], mode_raw};

  // =====================================================================
  // Storage
  // =====================================================================
  logic [7:0] mem_q [eeprom_pkg::MEM_DEPTH];
  logic [7:0] mem_d [eeprom_pkg::MEM_DEPTH];
  logic [7:0] latch_q [8], latch_d [8];
  logic [7:0] lvalid_q, lvalid_d;
  logic [7:0] base_q, base_d;

  // =====================================================================
  // Protocol state
  // =====================================================================
  eeprom_pkg::state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] tx_q, tx_d;
  logic rw_q, rw_d;
  logic page_q, page_d;
  logic span_q, span_d;
  logic [2:0] nbytes_q, nbytes_d;
  logic drv_q, drv_d;
  logic [31:0] tmr_q, tmr_d;
  logic commit;
  // Marks the SCL fall that follows START, so it is not counted as a bit
  localparam logic [3:0] BIT_ARM = 4'hF;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    rw_d = rw_q;
    page_d = page_q;
    span_d = span_q;
    nbytes_d = nbytes_q;
    drv_d = drv_q;
    tmr_d = tmr_q;
    latch_d = latch_q;
    lvalid_d = lvalid_q;
    base_d = base_q;
    commit = 1'b0;
    case (st_q)
      eeprom_pkg::ST_PROG: begin
        drv_d = 1'b0;
        if (tmr_q <= 32'h1) begin
          commit = 1'b1;
          st_d = eeprom_pkg::ST_IDLE;
        end else begin
          tmr_d = tmr_q - 32'h1;
        end
      end
      default: begin
        if (ev.stop) begin
          drv_d = 1'b0;
          st_d = eeprom_pkg::ST_IDLE;
          if (st_q == eeprom_pkg::ST_WDATA && lvalid_q != 8'h0) begin
            st_d = eeprom_pkg::ST_PROG;
            tmr_d = span_q ? 32'(TW_SPAN_CYCLES) : 32'(TW_CYCLES);
          end
        end else if (ev.start) begin
          drv_d = 1'b0;
          bit_d = BIT_ARM;
          st_d = eeprom_pkg::ST_SEL;
          lvalid_d = 8'h0;
        end else if (st_q != eeprom_pkg::ST_IDLE && ev.scl_rise) begin
          if (bit_q != eeprom_pkg::BIT_ACK) begin
            sh_d = {sh_q[6:0], ev.sda};
          end else if (st_q == eeprom_pkg::ST_RDATA && ev.sda) begin
            st_d = eeprom_pkg::ST_IDLE;
          end
        end else if (st_q != eeprom_pkg::ST_IDLE && ev.scl_fall) begin
          bit_d = (bit_q == eeprom_pkg::BIT_ACK || bit_q == BIT_ARM) ? 4'h0 : bit_q + 4'h1;
          drv_d = 1'b0;
          if (bit_q == eeprom_pkg::BIT_LAST && st_q != eeprom_pkg::ST_RDATA) begin
            case (st_q)
              eeprom_pkg::ST_SEL: begin
                if (sh_q[7:1] == eeprom_pkg::SELECT_CODE) begin
                  drv_d = 1'b1;
                  rw_d = sh_q[0];
                  page_d = ~mode_s_q[1];
                  span_d = 1'b0;
                  nbytes_d = 3'h0;
                end else begin
                  st_d = eeprom_pkg::ST_IDLE;
                end
              end
              eeprom_pkg::ST_ADDR: begin
                drv_d = 1'b1;
                ptr_d = sh_q;
                base_d = sh_q;
              end
              eeprom_pkg::ST_WDATA: begin
                drv_d = page_q || nbytes_q < 3'(eeprom_pkg::MULTI_MAX) ||
                        (base_q[2:0] == 3'h0 && ptr_q[7:3] == base_q[7:3]);
                if (drv_d) begin
                  nbytes_d = nbytes_q + 3'h1;
                  latch_d[ptr_q[2:0]] = sh_q;
                  lvalid_d[ptr_q[2:0]] = 1'b1;
                  if (ptr_q[7:3] != base_q[7:3]) span_d = 1'b1;
                  if (page_q) ptr_d = {ptr_q[7:3], ptr_q[2:0] + 3'h1};
                  else ptr_d = ptr_q + 8'h1;
                end
              end
              default: ;
            endcase
          end else if (bit_q == eeprom_pkg::BIT_ACK) begin
            case (st_q)
              eeprom_pkg::ST_SEL: begin
                if (rw_q) begin
                  st_d = eeprom_pkg::ST_RDATA;
                  tx_d = mem_q[ptr_q];
                  ptr_d = ptr_q + 8'h1;
                  drv_d = ~mem_q[ptr_q][7];
                end else begin
                  st_d = eeprom_pkg::ST_ADDR;
                end
              end
              eeprom_pkg::ST_ADDR: st_d = eeprom_pkg::ST_WDATA;
              eeprom_pkg::ST_RDATA: begin
                tx_d = mem_q[ptr_q];
                ptr_d = ptr_q + 8'h1;
                drv_d = ~mem_q[ptr_q][7];
              end
              default: ;
            endcase
          end else if (st_q == eeprom_pkg::ST_RDATA && bit_q < eeprom_pkg::BIT_LAST) begin
            drv_d = ~tx_q[3'(eeprom_pkg::BIT_LAST - bit_q - 4'h1)];
          end
        end
      end
    endcase
  end

  always_comb begin
    mem_d = mem_q;
    if (commit) begin
      for (int i = 0; i < 8; i++) begin
        if (lvalid_q[i]) begin
          // Multibyte beyond row end lands in the adjacent row
          if (!page_q && 3'(i) < base_q[2:0])
            mem_d[8'({base_q[7:3], 3'(i)} + 8'h8)] = latch_q[i];
          else
            mem_d[{base_q[7:3], 3'(i)}] = latch_q[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q <= eeprom_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      ptr_q <= 8'h0;
      tx_q <= 8'h0;
      rw_q <= 1'b0;
      page_q <= 1'b0;
      span_q <= 1'b0;
      nbytes_q <= 3'h0;
      drv_q <= 1'b0;
      tmr_q <= 32'h0;
      lvalid_q <= 8'h0;
      base_q <= 8'h0;
      mode_s_q <= 2'h3;
      for (int i = 0; i < 8; i++) latch_q[i] <= 8'h0;
      for (int i = 0; i < eeprom_pkg::MEM_DEPTH; i++) mem_q[i] <= eeprom_pkg::ERASED_BYTE;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      rw_q <= rw_d;
      page_q <= page_d;
      span_q <= span_d;
      nbytes_q <= nbytes_d;
      drv_q <= drv_d;
      tmr_q <= tmr_d;
      lvalid_q <= lvalid_d;
      base_q <= base_d;
      mode_s_q <= mode_s_d;
      latch_q <= latch_d;
      mem_q <= mem_d;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drv_q;
  assign busy = (st_q == eeprom_pkg::ST_PROG);
endmodule : i2c_eeprom

// file: eeprom_pkg.sv
package eeprom_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int ROW_BITS = 3;
  localparam int MULTI_MAX = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Arbitrary neutral select code, not a real part's
  localparam logic [6:0] SELECT_CODE = 7'h35;
  localparam int CLK_MHZ = 125;
  localparam int TW_MS = 10;
  localparam int TW_SPAN_MS = 20;
  localparam int TW_CYC = TW_MS * 1000 * CLK_MHZ;
  localparam int TW_SPAN_CYC = TW_SPAN_MS * 1000 * CLK_MHZ;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEL = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_PROG = 3'b101
  } state_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } bus_ev_t;
endpackage : eeprom_pkg

// file: sync_edge.sv
`timescale 1ns/1ps
// Two-flop synchroniser for SCL/SDA with edge and START/STOP detection
module sync_edge (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output eeprom_pkg::bus_ev_t ev
);
  logic [1:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;

  always_comb begin
    scl_s_d = {scl_s_q[0], scl_in};
    sda_s_d = {sda_s_q[0], sda_in};
    scl_p_d = scl_s_q[1];
    sda_p_d = sda_s_q[1];
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
    end
  end

  always_comb begin
    ev.scl_rise = scl_s_q[1] & ~scl_p_q;
    ev.scl_fall = ~scl_s_q[1] & scl_p_q;
    ev.start = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    ev.stop = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
    ev.sda = sda_s_q[1];
  end
endmodule : sync_edge

// file: i2c_eeprom_monitor.sv
`timescale 1ns/1ps
// ====================
// Program cycle and SDA drive checks
module i2c_eeprom_monitor #(
  parameter int TW_CYCLES = 50,
  parameter int TW_SPAN_CYCLES = 100
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic mode_in,
  input wire logic mode_oe_n,
  input wire logic busy
);
  localparam int MAX_WAIT = 1000;
  int len_q;
  int len_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Counter runs through the current program cycle for the bounds below and clears to zero while busy is low
  always_comb len_d = busy ? len_q + 1 : 0;
  always_ff @(posedge core_clk) len_q <= rstn ? len_d : 0;
  busy_no_ack_a: assert property (busy |-> !sda_oe)
    else $error("ack driven during program cycle");
  stop_starts_a: assert property ($rose(busy) |-> scl_in && sda_in)
    else $error("program cycle began without stop");
  prog_min_a: assert property ($rose(busy) |-> busy [*8])
    else $error("program cycle too short");
  prog_floor_a: assert property ($fell(busy) |-> len_q >= TW_CYCLES - 2)
    else $error("program cycle below write time");
  prog_cap_a: assert property (len_q <= TW_SPAN_CYCLES + 4)
    else $error("program cycle beyond span time");
  prog_ends_a: assert property ($rose(busy) |-> ##[1:MAX_WAIT] !busy)
    else $error("program cycle never ended");
  drive_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed with scl high");
  drive_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("sda drive too brief");
endmodule : i2c_eeprom_monitor

bind i2c_eeprom i2c_eeprom_monitor #(
  .TW_CYCLES(TW_CYCLES),
  .TW_SPAN_CYCLES(TW_SPAN_CYCLES)
) mon (
  .core_clk(core_clk),
  .rstn(rstn),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .mode_in(mode_in),
  .mode_oe_n(mode_oe_n),
  .busy(busy)
);

// file: i2c_master_model.sv
`timescale 1ns/1ps
// ====================
// Bus master: SCL stands high between frames, 80 ns bit period
module i2c_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data in low
  // Data moves 20 ns after the fall so it never looks like a start or stop
  task automatic bitx(input logic v, output logic s);
    #20 sda_low = !v;
    #20 scl = 1'b1;
    #20 s = sda;
    #20 scl = 1'b0;
  endtask : bitx
  task automatic start();
    #20 sda_low = 1'b0;
    #20 scl = 1'b1;
    #20 sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask : start
  task automatic stop();
    #20 sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40;
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask : wbyte
  task automatic rbyte(input logic mack, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, q[i]);
    bitx(!mack, s);
  endtask : rbyte
endmodule : i2c_master_model

// file: i2c_eeprom_tb.sv
`timescale 1ns/1ps
// ====================
// Write, poll and read-back scenarios
module i2c_eeprom_tb;
  localparam int TW = 200;
  localparam logic [7:0] SEL_W = {eeprom_pkg::SELECT_CODE, 1'b0};
  logic core_clk;
  logic rstn;
  logic mode_in;
  logic mode_oe_n;
  logic sda_out;
  logic sda_oe;
  logic busy;
  logic scl;
  logic m_low;
  wire sda = !(m_low || sda_oe);
  int n_errors;
  int compares;
  int busy_len;
  logic [7:0] exp_mem [256];
  logic ack;
  logic [7:0] q;
  i2c_eeprom #(.TW_CYCLES(TW), .TW_SPAN_CYCLES(2 * TW)) DUT (
    .core_clk(core_clk),
    .rstn(rstn),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .mode_in(mode_in),
    .mode_oe_n(mode_oe_n),
    .busy(busy)
  );
  i2c_master_model m (.scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  logic busy_was;
  // Length of the latest program cycle, restarted on each rising busy
  always @(posedge core_clk) begin
    busy_was <= busy;
    if (busy === 1'b1) busy_len <= (busy_was === 1'b1) ? busy_len + 1 : 1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input int n, input logic page);
    logic [7:0] dst;
    logic take;
    m.start();
    m.wbyte(SEL_W, ack);
    m.wbyte(a, ack);
    check(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      dst = page ? {a[7:3], 3'(a[2:0] + 3'(i))} : a + 8'(i);
      take = page || i < eeprom_pkg::MULTI_MAX || a[2:0] == 3'h0;
      m.wbyte(8'(i * 29) ^ a, ack);
      check(8'(ack), 8'(take));
      if (take) exp_mem[dst] = 8'(i * 29) ^ a;
    end
    m.stop();
  endtask : wr
  task automatic prog(input logic span);
    int w;
    m.start();
    m.wbyte(SEL_W, ack);
    m.stop();
    check(8'(ack), 8'h00);
    w = 0;
    while (busy === 1'b1 && w < 1000) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    check(8'(busy), 8'h00);
    check(8'(busy_len > TW + TW / 2), 8'(span));
    m.start();
    m.wbyte(SEL_W, ack);
    m.stop();
    check(8'(ack), 8'h01);
  endtask : prog
  task automatic rd(input logic [7:0] a, input int n);
    m.start();
    m.wbyte(SEL_W, ack);
    m.wbyte(a, ack);
    m.start();
    m.wbyte(SEL_W | 8'h01, ack);
    check(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, q);
      check(q, exp_mem[8'(a + 8'(i))]);
    end
    m.stop();
  endtask : rd
  task automatic cur_read(input logic [7:0] want);
    m.start();
    m.wbyte(SEL_W | 8'h01, ack);
    m.rbyte(1'b0, q);
    m.stop();
    check(q, want);
  endtask : cur_read
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    n_errors = 0;
    compares = 0;
    busy_len = 0;
    rstn = 1'b0;
    mode_in = 1'b1;
    mode_oe_n = 1'b0;
    foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
    repeat (5) @(posedge core_clk);
    #1 rstn = 1'b1;
    cur_read(8'hFF);
    @(posedge core_clk);
    #1 mode_in = 1'b0;
    // page wrap of one full row, nothing overwritten
    wr(8'h03, 8, 1'b1);
    prog(1'b0);
    rd(8'h00, 8);
    @(posedge core_clk);
    // floating pin; multibyte, four bytes across a row end, then eight from a row start
    #1 mode_oe_n = 1'b1;
    wr(8'h26, 4, 1'b0);
    prog(1'b1);
    rd(8'h24, 8);
    wr(8'h40, 8, 1'b0);
    prog(1'b0);
    rd(8'h40, 8);
    rd(8'hFF, 2);
    cur_read(exp_mem[1]);
    report_and_stop();
  end
endmodule : i2c_eeprom_tb
